/* File: rtl/dspg_defs.svh */
`ifndef DSPG_DEFS_SVH
`define DSPG_DEFS_SVH
// register byte offsets
`define DSPG_RUN_EN_OFS     12'h100
`define DSPG_SLEEP_EN_OFS   12'h110
`define DSPG_DEEP_EN_OFS    12'h128
`define DSPG_CLK_CFG_OFS    12'h060
`define DSPG_POWER_MODE_OFS 12'h200
`define DSPG_IRQ_STAT_OFS   12'h210
`define DSPG_IRQ_EN_OFS     12'h214
`define DSPG_IRQ_CLR_OFS    12'h218
// field positions
`define DSPG_AUTO_GATE_BIT  27
`define DSPG_PORT_BITS      8
`define DSPG_IRQ_BITS       2
`define DSPG_IRQ_FAULT_BIT  0
`define DSPG_IRQ_MODE_BIT   1
// reset values
`define DSPG_EN_RESET       8'h00
`define DSPG_CFG_RESET      1'b0
`define DSPG_MODE_RESET     2'h0
`define DSPG_IRQ_RESET      2'h0
`endif

/* File: rtl/dspg_fault_check.sv */
`include "dspg_defs.svh"
// registered per-access fault answer for gated ports
module dspg_fault_check
  import dspg_pkg::*;
#(
  parameter int PORTS = `DSPG_PORT_BITS
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // port access
  input  wire logic             portAccess,
  input  wire logic [2:0]       portSel,
  input  wire logic [PORTS-1:0] gateEn,
  // answer
  output logic                  portOk,
  output logic                  portFault
);
  logic okReg;
  logic okNext;
  logic faultReg;
  logic faultNext;

  always_comb
  begin
    okNext = 1'b0;
    faultNext = 1'b0;
    if (portAccess)
    begin
      okNext = gateEn[portSel];
      faultNext = !gateEn[portSel];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      okReg <= 1'b0;
      faultReg <= 1'b0;
    end
    else
    begin
      okReg <= okNext;
      faultReg <= faultNext;
    end
  end

  assign portOk = okReg;
  assign portFault = faultReg;
endmodule

/* File: rtl/dspg_pkg.sv */
package dspg_pkg;
  typedef enum logic [1:0]
  {
    DSPG_RUN   = 2'b00,
    DSPG_SLEEP = 2'b01,
    DSPG_DEEP  = 2'b10
  } dspg_mode_t;
endpackage

/* File: rtl/dspg_port_gate.sv */
// Added by the designer: the plain strobed port.
`include "dspg_defs.svh"
// Function
// - deep-sleep: set bit keeps port clocked
// - clear bit stops port clock
// - access to gated port gives bus fault
// - reset clears deep-sleep register to zero
// - bit 0 port A up to bit 7 port H
// - upper bits read zero, software preserves them
// - mode picks run, sleep or deep register
// - sleep registers used only with auto gating
module dspg_port_gate
  import dspg_pkg::*;
#(
  parameter int PORTS = `DSPG_PORT_BITS
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // register port
  input  wire logic [11:0]      regAddr,
  input  wire logic [31:0]      regWdata,
  input  wire logic             regWr,
  input  wire logic             regRd,
  output logic      [31:0]      regRdata,
  // power state from the power controller
  input  wire logic [1:0]       powerMode,
  // port accesses
  input  wire logic             portAccess,
  input  wire logic [2:0]       portSel,
  output logic                  portOk,
  output logic                  portFault,
  // gate enables, bit 0 port A .. bit 7 port H
  output logic      [PORTS-1:0] portClkEn,
  // interrupt
  output logic                  irq
);
  logic [PORTS-1:0] runEnReg, runEnNext;
  logic [PORTS-1:0] sleepEnReg, sleepEnNext;
  logic [PORTS-1:0] deepEnReg, deepEnNext;
  logic             autoGateReg, autoGateNext;
  logic [1:0]       modeReg, modeNext;
  logic [PORTS-1:0] clkEnReg, clkEnNext;
  logic [31:0]      rdataReg, rdataNext;
  logic [`DSPG_IRQ_BITS-1:0] irqStatReg, irqStatNext;
  logic [`DSPG_IRQ_BITS-1:0] irqEnReg, irqEnNext;
  logic [`DSPG_IRQ_BITS-1:0] irqSet, irqClr;
  logic             irqReg, irqNext;
  logic             faultPulse;

  function automatic logic hit(input logic [11:0] ofs);
    hit = (regAddr == ofs);
  endfunction

  dspg_fault_check #(.PORTS(PORTS)) faultChk
  (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .portAccess (portAccess),
    .portSel    (portSel),
    .gateEn     (clkEnReg),
    .portOk     (portOk),
    .portFault  (faultPulse)
  );

  // registers
  always_comb
  begin
    runEnNext = runEnReg;
    sleepEnNext = sleepEnReg;
    deepEnNext = deepEnReg;
    autoGateNext = autoGateReg;
    irqEnNext = irqEnReg;
    irqClr = '0;
    if (regWr)
    begin
      if (hit(`DSPG_RUN_EN_OFS))
        runEnNext = regWdata[PORTS-1:0];
      if (hit(`DSPG_SLEEP_EN_OFS))
        sleepEnNext = regWdata[PORTS-1:0];
      if (hit(`DSPG_DEEP_EN_OFS))
        deepEnNext = regWdata[PORTS-1:0];
      if (hit(`DSPG_CLK_CFG_OFS))
        autoGateNext = regWdata[`DSPG_AUTO_GATE_BIT];
      if (hit(`DSPG_IRQ_EN_OFS))
        irqEnNext = regWdata[`DSPG_IRQ_BITS-1:0];
      if (hit(`DSPG_IRQ_CLR_OFS))
        irqClr = regWdata[`DSPG_IRQ_BITS-1:0];
    end
  end

  // gate selection; registered so the enables are glitch free
  always_comb
  begin
    modeNext = powerMode;
    clkEnNext = runEnReg;
    if (autoGateReg)
    begin
      unique case (dspg_mode_t'(modeReg))
        DSPG_RUN:   clkEnNext = runEnReg;
        DSPG_SLEEP: clkEnNext = sleepEnReg;
        DSPG_DEEP:  clkEnNext = deepEnReg;
        default:    clkEnNext = runEnReg;
      endcase
    end
  end

  // events: fault on gated port, power mode change; set beats clear
  always_comb
  begin
    irqSet = '0;
    irqSet[`DSPG_IRQ_FAULT_BIT] = faultPulse;
    irqSet[`DSPG_IRQ_MODE_BIT] = (powerMode != modeReg);
    irqStatNext = (irqStatReg & ~irqClr) | irqSet;
    irqNext = |(irqStatNext & irqEnNext);
  end

  // read data, reserved bits zero
  always_comb
  begin
    rdataNext = 32'h0000_0000;
    if (regRd)
    begin
      if (hit(`DSPG_RUN_EN_OFS))
        rdataNext[PORTS-1:0] = runEnReg;
      else if (hit(`DSPG_SLEEP_EN_OFS))
        rdataNext[PORTS-1:0] = sleepEnReg;
      else if (hit(`DSPG_DEEP_EN_OFS))
        rdataNext[PORTS-1:0] = deepEnReg;
      else if (hit(`DSPG_CLK_CFG_OFS))
        rdataNext[`DSPG_AUTO_GATE_BIT] = autoGateReg;
      else if (hit(`DSPG_POWER_MODE_OFS))
        rdataNext[1:0] = modeReg;
      else if (hit(`DSPG_IRQ_STAT_OFS))
        rdataNext[`DSPG_IRQ_BITS-1:0] = irqStatReg;
      else if (hit(`DSPG_IRQ_EN_OFS))
        rdataNext[`DSPG_IRQ_BITS-1:0] = irqEnReg;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      runEnReg <= `DSPG_EN_RESET;
      sleepEnReg <= `DSPG_EN_RESET;
      deepEnReg <= `DSPG_EN_RESET;
      autoGateReg <= `DSPG_CFG_RESET;
      modeReg <= `DSPG_MODE_RESET;
      clkEnReg <= `DSPG_EN_RESET;
      rdataReg <= 32'h0000_0000;
      irqStatReg <= `DSPG_IRQ_RESET;
      irqEnReg <= `DSPG_IRQ_RESET;
      irqReg <= 1'b0;
    end
    else
    begin
      runEnReg <= runEnNext;
      sleepEnReg <= sleepEnNext;
      deepEnReg <= deepEnNext;
      autoGateReg <= autoGateNext;
      modeReg <= modeNext;
      clkEnReg <= clkEnNext;
      rdataReg <= rdataNext;
      irqStatReg <= irqStatNext;
      irqEnReg <= irqEnNext;
      irqReg <= irqNext;
    end
  end

  assign regRdata = rdataReg;
  assign portClkEn = clkEnReg;
  assign portFault = faultPulse;
  assign irq = irqReg;
endmodule

/* File: tb/dspg_gate_sva.sv */
module dspg_gate_sva
#(
  parameter int PORTS = 8
)
(
  // clock and reset
  input wire logic             core_clk,
  input wire logic             rstn,
  // register port
  input wire logic [11:0]      regAddr,
  input wire logic             regWr,
  input wire logic             regRd,
  input wire logic [31:0]      regRdata,
  // power state and port access
  input wire logic [1:0]       powerMode,
  input wire logic             portAccess,
  input wire logic [2:0]       portSel,
  input wire logic             portOk,
  input wire logic             portFault,
  input wire logic [PORTS-1:0] portClkEn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  chk_gated_fault: assert property
    (portAccess && !portClkEn[portSel] |=> portFault && !portOk)
    else $error("no fault on gated port");
  chk_clocked_ok: assert property
    (portAccess && portClkEn[portSel] |=> portOk && !portFault)
    else $error("no answer on clocked port");
  chk_no_access: assert property
    (!portAccess |=> !portOk && !portFault)
    else $error("answer without access");
  chk_reset_clear: assert property
    (disable iff (1'b0) !rstn |=> portClkEn == '0 && !portOk)
    else $error("reset left enables set");
  chk_rd_upper: assert property
    (regRd && regAddr inside {12'h100, 12'h110, 12'h128}
      |=> regRdata[31:8] == '0)
    else $error("upper enable bits not zero");
  chk_rd_idle: assert property
    (!regRd |=> regRdata == '0)
    else $error("read data outside read slot");
  chk_unmapped_rd: assert property
    (regRd && regAddr == 12'h004 |=> regRdata == '0)
    else $error("unmapped read not zero");
  // pipeline is two deep, so four quiet cycles leave no change in flight
  chk_gate_hold: assert property
    ((!regWr && $stable(powerMode))[*4] |=> $stable(portClkEn))
    else $error("enables moved while quiet");
endmodule
bind dspg_port_gate dspg_gate_sva #(.PORTS(PORTS)) chk (.core_clk,
  .rstn, .regAddr, .regWr, .regRd, .regRdata, .powerMode, .portAccess,
  .portSel, .portOk, .portFault, .portClkEn);

/* File: tb/test_deep_sleep_port_clock_gating.sv */
module test_deep_sleep_port_clock_gating import dspg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 0, rstn = 0, regWr = 0, regRd = 0;
  logic        portAccess = 0, portOk, portFault, irq;
  logic [11:0] regAddr = '0;
  logic [31:0] regWdata = '0, regRdata, seed = 32'h8CFB;
  logic [1:0]  powerMode = DSPG_RUN;
  logic [2:0]  portSel = '0;
  logic [7:0]  portClkEn;
  int          failures = 0, samples_checked = 0, flt;
  int          runE = 0, slpE = 0, deepE = 0, autoSel = 0;
  always #2 core_clk = ~core_clk;
  dspg_port_gate DUT (.core_clk, .rstn, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .powerMode, .portAccess, .portSel, .portOk,
    .portFault, .portClkEn, .irq);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // illegal mode 3 behaves as run
  function automatic int gate();
    if (autoSel == 0 || powerMode == 2'h0 || powerMode == 2'h3)
      return runE;
    return powerMode == 2'h1 ? slpE : deepE;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask
  task automatic rd(logic [11:0] a, int e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge core_clk);
    regRd <= 1'h0;
    #1 chk("rdata", e, regRdata);
  endtask
  task automatic sett();
    repeat (3) @(posedge core_clk);
    #1 chk("clkEn", gate(), {24'h0, portClkEn});
  endtask
  task automatic test_done();
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    failures++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'h1;
    rd(12'h128, 0);
    wr(12'h060, 32'h0800_0000);
    autoSel = 1;
    wr(12'h214, 32'h1);
    for (int m = 0; m < 4; m++)
    begin
      runE = xs();
      slpE = xs();
      deepE = xs();
      wr(12'h100, runE);
      wr(12'h110, slpE);
      wr(12'h128, deepE);
      runE &= 255;
      slpE &= 255;
      deepE &= 255;
      rd(12'h128, deepE);
      @(posedge core_clk) powerMode <= m[1:0];
      sett();
      rd(12'h200, m[1:0]);
      flt = gate() != 255;
      for (int p = 0; p < 8; p++)
      begin
        @(posedge core_clk);
        portAccess <= 1'h1;
        portSel <= p[2:0];
        @(posedge core_clk);
        portAccess <= 1'h0;
        #1 chk("fault", ((gate() >> p) & 1) == 0, portFault);
        chk("ok", (gate() >> p) & 1, portOk);
      end
      @(posedge core_clk);
      #1 chk("irq", flt, irq);
      wr(12'h218, 32'h1);
      @(posedge core_clk);
      #1 chk("irq", 0, irq);
    end
    @(posedge core_clk) powerMode <= DSPG_DEEP;
    sett();
    wr(12'h060, 32'h0);
    autoSel = 0;
    sett();
    rd(12'h004, 0);
    @(posedge core_clk) rstn <= 1'h0;
    @(posedge core_clk) rstn <= 1'h1;
    runE = 0;
    slpE = 0;
    deepE = 0;
    sett();
    rd(12'h128, 0);
    test_done();
  end
endmodule
